// file: hw/iea_pkg.sv
/*
 * Constants, field layouts and carrier types for the interrupt enable and
 * acceptance block. Assumes a single 100 MHz clock and an AHB-Lite master.
 */
package iea_pkg;
	localparam int NSRC = 8;
	localparam int EN_LATENCY = 2;
	localparam int CLK_PERIOD_NS = 10;

	// Register byte offsets
	localparam logic [7:0] OFF_MODE_LO = 8'h00;
	localparam logic [7:0] OFF_MODE_HI = 8'h04;
	localparam logic [7:0] OFF_VECTOR = 8'h08;
	localparam logic [7:0] OFF_MASK = 8'h0c;
	localparam logic [7:0] OFF_CLEAR = 8'h10;
	localparam logic [7:0] OFF_PEND = 8'h14;
	localparam logic [7:0] OFF_KEY = 8'h18;
	localparam logic [7:0] OFF_EDGE = 8'h1c;
	localparam logic [7:0] OFF_CORE = 8'h20;

	// Field positions
	localparam int MODE_SENSE_POS = 0;
	localparam int MODE_PRIO_POS = 4;
	localparam int MASK_WFLAG_POS = 31;
	localparam int VEC_BASE_LSB = 9;
	localparam int SH_CSS_POS = 4;
	localparam int SH_PSS_POS = 8;
	localparam int SH_OFF_POS = 31;

	// Sensitivity codes
	localparam logic [1:0] SENSE_LOW = 2'h0;
	localparam logic [1:0] SENSE_HIGH = 2'h1;
	localparam logic [1:0] SENSE_FALL = 2'h2;
	localparam logic [1:0] SENSE_RISE = 2'h3;

	// Emergency unlock keys
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;

	// Core-side move selectors
	localparam logic [1:0] CP_SEL_STATUS = 2'h0;
	localparam logic [1:0] CP_SEL_ENABLE = 2'h1;
	localparam logic [1:0] CP_SEL_SHADOW = 2'h2;

	// Reset values and interrupt vector address
	localparam logic [2:0] RST_MASK = 3'h0;
	localparam logic [22:0] RST_VEC_BASE = 23'h000000;
	localparam logic RST_SHADOW_OFF = 1'b1;
	localparam logic [31:0] INT_VEC_ADDR = 32'hbfc00400;

	typedef struct packed {
		logic [2:0] prio;
		logic [1:0] sense;
	} iea_src_cfg_t;

	typedef struct packed {
		logic error_level_flag;
		logic exl;
		logic ie;
	} iea_stat_t;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_READ = 2'b01,
		BUS_WRITE = 2'b10
	} iea_bus_st_t;

	typedef enum logic [1:0] {
		KEY_LOCKED = 2'b00,
		KEY_HALF = 2'b01,
		KEY_OPEN = 2'b11
	} iea_key_t;

	// Vector code of source idx: (idx + 1) * 16, source 1 gives 9'h020
	function automatic logic [8:0] vec_code_of(input logic [2:0] idx);
		return {1'b0, {1'b0, idx} + 4'h1, 4'h0};
	endfunction
endpackage

// file: hw/iea_top.sv
/*
 * Interrupt enable and acceptance: source detection, pending latches,
 * priority arbitration, status flags with two-cycle enable latency, core
 * notification, shadow bank select, and an AHB-Lite register slave.
 * Assumes source inputs are asynchronous and the core issues its status
 * moves and return/barrier ops as one-cycle pulses on mclk.
 */
// What this block does
// - Accept interrupts only with error flag 0, exception flag 0, enable 1.
// - New enable state becomes effective two clocks after the enabling instruction.
// - Failing any condition disables; takes effect two clocks later too.
// - Alias write nonzero sets global enable; zero clears it.
// - Status move in either mode and on/off ops also set or clear enable.
// - Requests stay pending while globally disabled.
// - No request latches from a source at priority zero.
// - Taking sets the exception flag; exception return clears it and the error flag.
// - Winner's vector into vector register, level into mask and to core.
// - Notification sets exception flag and saves interrupted PC.
// - With shadow banks on, accepted level selects the current bank.
// - Acceptance suspends execution and branches to the interrupt vector.
// - Sense code 01 selects high-level detection.
// - Three-bit priority per source; 010 is level 2, 000 disables.
// - Edge register writes need keys 0x55 then 0xAA first.
// - Writing a source's vector code to the clear register clears it.
// - Mask field loads only when the same write sets the flag.
// - Barrier stalls until configuration writes have taken effect.
// - Code 10 selects falling edge, code 00 low level.
// - Levels sampled every clock; edges compare previous with current.
// - Clearing the accepted source also clears the vector register.
`timescale 1ns/100ps
module iea_top
	import iea_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Interrupt sources
	input wire logic [NSRC-1:0] src_in,
	// Core operations
	input wire logic cp_wr,
	input wire logic [1:0] cp_sel,
	input wire logic [31:0] cp_wdata,
	input wire logic irq_on_op,
	input wire logic irq_off_op,
	input wire logic exception_return_op,
	input wire logic exc_take,
	input wire logic err_take,
	input wire logic sync_req,
	input wire logic [31:0] cur_pc,
	// Core notification
	output logic [2:0] core_level,
	output logic core_take,
	output logic redirect,
	output logic [31:0] redirect_pc,
	output logic [31:0] return_pc_save,
	output logic [2:0] stat_flags,
	output logic [2:0] bank_sel,
	output logic core_stall
);
	////////////////////////////////////////////////////////////////////////
	// State
	iea_bus_st_t st_q;
	logic [7:0] adr_q;
	logic hreadyout_q;
	logic [31:0] hrdata_q;
	iea_src_cfg_t cfg_q [NSRC];
	logic [2:0] mask_q;
	logic [22:0] vec_base_q;
	logic [8:0] vec_code_q;
	logic [NSRC-1:0] pend_q;
	iea_key_t key_q;
	logic [3:0] emsense_q;
	logic [NSRC-1:0] s1_q, s2_q, s3_q, filt_q, prev_q;
	iea_stat_t stat_q;
	logic en_p1_q, en_eff_q;
	logic [31:0] epc_q;
	logic ssd_q;
	logic [2:0] css_q, pss_q;
	logic [2:0] level_q;
	logic take_q, redirect_q, stall_q;
	logic [31:0] redirect_pc_q;

	////////////////////////////////////////////////////////////////////////
	// Bus decode
	wire addr_ok = hsel & htrans[1] & hready;
	wire rd_load = (st_q == BUS_READ) & ~hreadyout_q;
	wire wr_en = (st_q == BUS_WRITE) & hready;
	wire wr_mode_lo = wr_en & (adr_q == OFF_MODE_LO);
	wire wr_mode_hi = wr_en & (adr_q == OFF_MODE_HI);
	wire wr_vector = wr_en & (adr_q == OFF_VECTOR);
	wire wr_mask = wr_en & (adr_q == OFF_MASK);
	wire wr_clear = wr_en & (adr_q == OFF_CLEAR);
	wire wr_key = wr_en & (adr_q == OFF_KEY);
	wire wr_edge = wr_en & (adr_q == OFF_EDGE);
	wire [31:0] core_word = {ssd_q, 20'h00000, pss_q, 1'b0, css_q, 1'b0, stat_q};
	logic [31:0] mode_word [2];
	logic [31:0] rd_mux;

	always_comb begin
		unique case (adr_q)
			OFF_MODE_LO: rd_mux = mode_word[0];
			OFF_MODE_HI: rd_mux = mode_word[1];
			OFF_VECTOR: rd_mux = {vec_base_q, vec_code_q};
			OFF_MASK: rd_mux = {29'h0, mask_q};
			OFF_PEND: rd_mux = {24'h0, pend_q};
			OFF_KEY: rd_mux = {30'h0, key_q};
			OFF_EDGE: rd_mux = {28'h0, emsense_q};
			OFF_CORE: rd_mux = core_word;
			// Unmapped and write-only offsets read zero
			default: rd_mux = 32'h0;
		endcase
	end

	// Reads take one wait state so a write just before is always visible
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_q <= BUS_IDLE;
			adr_q <= 8'h00;
			hreadyout_q <= 1'b1;
			hrdata_q <= 32'h0;
		end else if (rd_load) begin
			hrdata_q <= rd_mux;
			hreadyout_q <= 1'b1;
		end else if (hready) begin
			st_q <= addr_ok ? (hwrite ? BUS_WRITE : BUS_READ) : BUS_IDLE;
			adr_q <= haddr[7:0];
			hreadyout_q <= ~(addr_ok & ~hwrite);
		end
	end

	assign hreadyout = hreadyout_q;
	assign hresp = 1'b0 & hsize[0];
	assign hrdata = hrdata_q;

	////////////////////////////////////////////////////////////////////////
	// Source synchronisers and detection
	logic [NSRC-1:0] filt_d, hit, prio_zero, clr_hit;
	iea_src_cfg_t cfg_d [NSRC];

	// A change counts once the second and third stages agree
	assign filt_d = (s2_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			filt_q <= '0;
			prev_q <= '0;
		end else begin
			s1_q <= src_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			filt_q <= filt_d;
			prev_q <= filt_q;
		end
	end

	for (genvar i = 0; i < NSRC; i++) begin : g_src
		wire [7:0] wbyte = hwdata[(i % 4) * 8 +: 8];
		wire wr_this = (i < 4) ? wr_mode_lo : wr_mode_hi;
		assign cfg_d[i] = wr_this ? '{prio: wbyte[MODE_PRIO_POS +: 3],
			sense: wbyte[MODE_SENSE_POS +: 2]} : cfg_q[i];
		assign prio_zero[i] = (cfg_q[i].prio == 3'h0);
		assign clr_hit[i] = wr_clear & (hwdata[8:0] == vec_code_of(3'(i)));
		assign hit[i] = (cfg_q[i].sense == SENSE_HIGH) ? filt_q[i] :
			(cfg_q[i].sense == SENSE_LOW) ? ~filt_q[i] :
			(cfg_q[i].sense == SENSE_FALL) ? (prev_q[i] & ~filt_q[i]) :
			(~prev_q[i] & filt_q[i]);

		always_ff @(posedge mclk or posedge rst) begin
			if (rst) begin
				cfg_q[i] <= '0;
			end else begin
				cfg_q[i] <= cfg_d[i];
			end
		end
		assign mode_word[i / 4][(i % 4) * 8 +: 8] = {1'b0, cfg_q[i].prio, 2'b00,
			cfg_q[i].sense};
	end

	// pending latch, set wins over clear, level 0 never latches
	wire [NSRC-1:0] pend_d = (pend_q & ~clr_hit) | (hit & ~prio_zero);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pend_q <= '0;
		end else begin
			pend_q <= pend_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Arbitration
	logic [2:0] best_lvl, best_idx;

	// strict compare keeps the lowest index on a tie
	always_comb begin
		best_lvl = 3'h0;
		best_idx = 3'h0;
		for (int i = 0; i < NSRC; i++) begin
			if (pend_q[i] && (cfg_q[i].prio > best_lvl)) begin
				best_lvl = cfg_q[i].prio;
				best_idx = 3'(i);
			end
		end
	end

	// accept only through the delayed enable
	wire take_go = en_eff_q & ~take_q & (best_lvl != 3'h0) & (best_lvl > mask_q);
	wire en_now = ~stat_q.error_level_flag & ~stat_q.exl & stat_q.ie;

	////////////////////////////////////////////////////////////////////////
	// Vector, mask and emergency registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mask_q <= RST_MASK;
			vec_base_q <= RST_VEC_BASE;
			vec_code_q <= 9'h000;
		end else begin
			if (wr_vector) begin
				vec_base_q <= hwdata[31:VEC_BASE_LSB];
			end
			if (take_go) begin
				vec_code_q <= vec_code_of(best_idx);
				mask_q <= best_lvl;
			end else begin
				// clearing the accepted source clears the vector
				if (wr_clear && (hwdata[8:0] == vec_code_q)) begin
					vec_code_q <= 9'h000;
				end
				// mask loads with its write flag only
				if (wr_mask && hwdata[MASK_WFLAG_POS]) begin
					mask_q <= hwdata[2:0];
				end
			end
		end
	end

	// keyed unlock; any other key value relocks
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			key_q <= KEY_LOCKED;
			emsense_q <= 4'h0;
		end else if (wr_key) begin
			key_q <= (hwdata[7:0] == KEY_FIRST) ? KEY_HALF :
				((hwdata[7:0] == KEY_SECOND) && (key_q == KEY_HALF)) ? KEY_OPEN :
				KEY_LOCKED;
		end else if (wr_edge) begin
			if (key_q == KEY_OPEN) begin
				emsense_q <= hwdata[3:0];
			end
			key_q <= KEY_LOCKED;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status flags and enable pipeline
	iea_stat_t stat_d;

	always_comb begin
		stat_d = stat_q;
		if (cp_wr && (cp_sel == CP_SEL_STATUS)) begin
			stat_d = cp_wdata[2:0];
		end
		if (cp_wr && (cp_sel == CP_SEL_ENABLE)) begin
			stat_d.ie = |cp_wdata;
		end
		if (irq_on_op) begin
			stat_d.ie = 1'b1;
		end
		if (irq_off_op) begin
			stat_d.ie = 1'b0;
		end
		if (exception_return_op) begin
			stat_d.exl = 1'b0;
			stat_d.error_level_flag = 1'b0;
		end
		if (exc_take) begin
			stat_d.exl = 1'b1;
		end
		if (err_take) begin
			stat_d.error_level_flag = 1'b1;
		end
		if (take_go) begin
			stat_d.exl = 1'b1;
		end
	end

	// two-stage pipeline; a take flushes it
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			stat_q <= '0;
			en_p1_q <= 1'b0;
			en_eff_q <= 1'b0;
		end else begin
			stat_q <= stat_d;
			en_p1_q <= take_go ? 1'b0 : en_now;
			en_eff_q <= take_go ? 1'b0 : en_p1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Core notification, PC save and shadow bank
	wire exception_return_op_go = exception_return_op & ~take_go;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			level_q <= 3'h0;
			take_q <= 1'b0;
			redirect_q <= 1'b0;
			redirect_pc_q <= 32'h0;
			epc_q <= 32'h0;
			ssd_q <= RST_SHADOW_OFF;
			css_q <= 3'h0;
			pss_q <= 3'h0;
		end else begin
			take_q <= take_go;
			redirect_q <= take_go | exception_return_op_go;
			if (cp_wr && (cp_sel == CP_SEL_SHADOW)) begin
				ssd_q <= cp_wdata[SH_OFF_POS];
				css_q <= cp_wdata[SH_CSS_POS +: 3];
				pss_q <= cp_wdata[SH_PSS_POS +: 3];
			end
			if (take_go) begin
				level_q <= best_lvl;
				epc_q <= cur_pc;
				redirect_pc_q <= INT_VEC_ADDR;
				if (!ssd_q) begin
					pss_q <= css_q;
					css_q <= best_lvl;
				end
			end else if (exception_return_op_go) begin
				redirect_pc_q <= epc_q;
				if (!ssd_q) begin
					css_q <= pss_q;
				end
			end
		end
	end

	// barrier holds while a write or enable change is in flight
	wire cfg_busy = (st_q == BUS_WRITE) | (en_now != en_p1_q) | (en_p1_q != en_eff_q);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			stall_q <= 1'b0;
		end else begin
			stall_q <= sync_req | (stall_q & cfg_busy);
		end
	end

	assign core_level = level_q;
	assign core_take = take_q;
	assign redirect = redirect_q;
	assign redirect_pc = redirect_pc_q;
	assign return_pc_save = epc_q;
	assign stat_flags = stat_q;
	assign bank_sel = css_q;
	assign core_stall = stall_q;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_enable_rise;
		$rose(en_now) ##1 en_now;
	endsequence

	// Enable state seen three samples back, allowing the two-cycle disable latency
	chk_accept_gate: assert property (take_q |-> $past(en_eff_q) && $past(stat_q.ie, 3)
		&& !$past(stat_q.exl, 3) && !$past(stat_q.error_level_flag, 3))
		else $error("take without enable");
	chk_enable_delay: assert property (s_enable_rise |-> !en_eff_q ##1 en_eff_q)
		else $error("enable not two cycles late");
	chk_disable_delay: assert property ($fell(en_now) |-> ##2 !en_eff_q)
		else $error("disable not effective after two cycles");
	chk_alias_write: assert property (cp_wr && cp_sel == CP_SEL_ENABLE && !irq_on_op
		&& !irq_off_op |=> stat_q.ie == $past(|cp_wdata))
		else $error("alias write wrong");
	chk_zero_prio: assert property ((pend_q & ~$past(pend_q) & $past(prio_zero)) == '0)
		else $error("level zero source latched");
	chk_take_loads: assert property (take_q |-> level_q == $past(best_lvl)
		&& mask_q == level_q && vec_code_q == vec_code_of($past(best_idx)))
		else $error("acceptance load wrong");
	chk_take_save: assert property (take_q |-> stat_q.exl && return_pc_save == $past(cur_pc)
		&& redirect_q && redirect_pc_q == INT_VEC_ADDR)
		else $error("acceptance save wrong");
	chk_bank_switch: assert property (take_q && !$past(ssd_q) |-> css_q == level_q)
		else $error("bank not switched");
	chk_exception_return_op_restore: assert property (exception_return_op && !take_go && !exc_take
		|=> !stat_q.exl && redirect_q && redirect_pc_q == $past(epc_q))
		else $error("return restore wrong");
	chk_mask_flag: assert property (wr_mask && !hwdata[MASK_WFLAG_POS] && !take_go
		|=> $stable(mask_q))
		else $error("mask loaded without flag");
	chk_edge_lock: assert property (wr_edge && key_q != KEY_OPEN |=> $stable(emsense_q))
		else $error("locked edge register written");
	chk_vector_clear: assert property (wr_clear && hwdata[8:0] == vec_code_q && !take_go
		|=> vec_code_q == 9'h000)
		else $error("vector not cleared");
	chk_sync_stall: assert property (sync_req |=> stall_q)
		else $error("barrier did not stall");
endmodule

// file: bench/iea_core_model.sv
/*
 * Behavioural core model: issues coprocessor moves and pipeline ops as
 * one-cycle pulses and follows the block's branch redirects.
 * Assumes it shares mclk and rst with iea_top and is commanded by the bench.
 */
`timescale 1ns/100ps
module iea_core_model
	import iea_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// From the block
	input wire logic redirect,
	input wire logic [31:0] redirect_pc,
	input wire logic core_stall,
	// To the block
	output logic cp_wr,
	output logic [1:0] cp_sel,
	output logic [31:0] cp_wdata,
	output logic irq_on_op,
	output logic irq_off_op,
	output logic exception_return_op,
	output logic exc_take,
	output logic err_take,
	output logic sync_req,
	output logic [31:0] cur_pc
);

initial begin
	{cp_wr, irq_on_op, irq_off_op, exception_return_op, exc_take, err_take, sync_req} = 7'h00;
	cp_sel = 2'h0;
	cp_wdata = 32'h00000000;
end

////////////////////////////////////////////////////////////////////////////////
// PC follows branches
// Holding the PC steady keeps the saved value predictable
always @(posedge mclk or posedge rst) begin
	if (rst) begin
		cur_pc <= 32'h00001000;
	end else if (redirect === 1'b1) begin
		cur_pc <= redirect_pc;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Kinds: 0 status, 1 alias, 2 shadow, 3 on, 4 off, 5 return, 6 exc, 7 err, 8 barrier
task automatic op(input logic [3:0] kind, input logic [31:0] data);
	@(posedge mclk);
	while (core_stall === 1'b1) @(posedge mclk);
	cp_wr <= (kind < 4'h3);
	cp_sel <= kind[1:0];
	cp_wdata <= data;
	irq_on_op <= (kind == 4'h3);
	irq_off_op <= (kind == 4'h4);
	exception_return_op <= (kind == 4'h5);
	exc_take <= (kind == 4'h6);
	err_take <= (kind == 4'h7);
	sync_req <= (kind == 4'h8);
	@(posedge mclk);
	{cp_wr, irq_on_op, irq_off_op, exception_return_op, exc_take, err_take, sync_req} <= 7'h00;
endtask
endmodule

// file: bench/iea_top_tb.sv
/*
 * Self-checking bench for iea_top: AHB-Lite register tasks, a core model
 * for moves and ops, and source stimulus on src_in.
 * Assumes a single 100 MHz clock and the one-slave AHB-Lite map of the block.
 */
`timescale 1ns/100ps
module iea_top_tb
	import iea_pkg::*;
;
logic mclk, rst, hsel, hwrite, hreadyout, hresp;
logic [31:0] haddr, hwdata, hrdata, redirect_pc, return_pc_save, cur_pc, cp_wdata;
logic [1:0] htrans, cp_sel;
logic [2:0] hsize, core_level, stat_flags, bank_sel;
logic [NSRC-1:0] src_in;
logic cp_wr, irq_on_op, irq_off_op, exception_return_op, exc_take, err_take, sync_req;
logic core_take, redirect, core_stall;
int n_mismatch, checked, n_take, cyc, i, k;
logic [3:0] on_k [3] = '{4'h0, 4'h1, 4'h3};
logic [3:0] off_k [3] = '{4'h0, 4'h1, 4'h4};
logic [31:0] on_d [3] = '{32'h00000001, 32'h00000005, 32'h00000000};

iea_top i_iea_top (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .src_in(src_in),
	.cp_wr(cp_wr), .cp_sel(cp_sel), .cp_wdata(cp_wdata), .irq_on_op(irq_on_op),
	.irq_off_op(irq_off_op), .exception_return_op(exception_return_op),
	.exc_take(exc_take), .err_take(err_take), .sync_req(sync_req), .cur_pc(cur_pc),
	.core_level(core_level), .core_take(core_take), .redirect(redirect),
	.redirect_pc(redirect_pc), .return_pc_save(return_pc_save),
	.stat_flags(stat_flags), .bank_sel(bank_sel), .core_stall(core_stall));

iea_core_model i_iea_core_model (.mclk(mclk), .rst(rst), .redirect(redirect),
	.redirect_pc(redirect_pc), .core_stall(core_stall), .cp_wr(cp_wr), .cp_sel(cp_sel),
	.cp_wdata(cp_wdata), .irq_on_op(irq_on_op), .irq_off_op(irq_off_op),
	.exception_return_op(exception_return_op), .exc_take(exc_take),
	.err_take(err_take), .sync_req(sync_req), .cur_pc(cur_pc));

initial begin
	mclk = 1'b0;
	forever #(CLK_PERIOD_NS / 2) mclk = ~mclk;
end

////////////////////////////////////////////////////////////////////////////////
task automatic end_of_test();
	$display("counts: checked=%0d mismatches=%0d", checked, n_mismatch);
	if (n_mismatch == 0 && checked > 0) begin
		$display("TB: PASS");
	end else begin
		$display("TB: FAIL");
	end
	$finish;
endtask

// Whole run needs a few hundred cycles; the ceiling leaves wide margin
always @(posedge mclk) begin
	cyc++;
	if (core_take === 1'b1) n_take++;
	if (cyc == 20000) begin
		n_mismatch++;
		end_of_test();
	end
end

task automatic check(input logic [31:0] got, input logic [31:0] exp);
	checked++;
	if (got !== exp) begin
		n_mismatch++;
		$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
	end
endtask

// Entered just after a rising edge; waits on hready, never a fixed count
task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
	output logic [31:0] rdv);
	hsel <= 1'b1;
	haddr <= {24'h000000, a};
	htrans <= 2'h2;
	hwrite <= wr;
	hsize <= 3'h2;
	@(posedge mclk);
	while (hreadyout !== 1'b1) @(posedge mclk);
	hsel <= 1'b0;
	htrans <= 2'h0;
	hwdata <= wd;
	@(posedge mclk);
	while (hreadyout !== 1'b1) @(posedge mclk);
	rdv = hrdata;
endtask

task automatic wr(input logic [7:0] a, input logic [31:0] d);
	logic [31:0] v;
	bus(1'b1, a, d, v);
endtask

task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
	logic [31:0] v;
	bus(1'b0, a, 32'h00000000, v);
	check(v, exp);
endtask

task automatic cyc_wait(input int n);
	repeat (n) @(posedge mclk);
endtask

// Handler order: drop the source, read vector first, clear, return
task automatic handler();
	src_in[1] <= 1'b0;
	cyc_wait(8);
	rdchk(OFF_VECTOR, 32'h00000020);
	wr(OFF_CLEAR, 32'h00000020);
	i_iea_core_model.op(4'h5, 32'h0);
	wr(OFF_MASK, 32'h80000000);
endtask

////////////////////////////////////////////////////////////////////////////////
initial begin
	rst = 1'b1;
	{hsel, hwrite} = 2'b00;
	haddr = 32'h00000000;
	hwdata = 32'h00000000;
	htrans = 2'h0;
	hsize = 3'h2;
	// Low-level and falling-edge sources idle high
	src_in = 8'h50;
	{n_mismatch, checked, n_take, cyc} = 128'h0;
	repeat (16) @(posedge mclk);
	rst <= 1'b0;
	@(posedge mclk);
	rdchk(OFF_CORE, 32'h80000000);
	rdchk(8'h3c, 32'h00000000);
	check({31'h0, hresp}, 32'h0);
	check({29'h0, stat_flags}, 32'h0);
	wr(OFF_MASK, 32'h00000005);
	rdchk(OFF_MASK, 32'h00000000);
	wr(OFF_MASK, 32'h80000005);
	rdchk(OFF_MASK, 32'h00000005);
	wr(OFF_MASK, 32'h80000000);
	$display("test reset and mask done");

	wr(OFF_MODE_LO, 32'h00000001);
	src_in[0] <= 1'b1;
	cyc_wait(8);
	rdchk(OFF_PEND, 32'h00000000);
	wr(OFF_MODE_LO, 32'h00000021);
	cyc_wait(8);
	rdchk(OFF_PEND, 32'h00000001);
	src_in[0] <= 1'b0;
	cyc_wait(8);
	wr(OFF_CLEAR, 32'h00000010);
	rdchk(OFF_PEND, 32'h00000000);
	wr(OFF_MODE_LO, 32'h00000000);
	// Sources 4..7 at level 2: low, high, falling, rising
	wr(OFF_MODE_HI, 32'h23222120);
	cyc_wait(8);
	rdchk(OFF_PEND, 32'h00000000);
	src_in[7:4] <= 4'ha;
	cyc_wait(8);
	rdchk(OFF_PEND, 32'h000000f0);
	src_in[7:4] <= 4'h5;
	cyc_wait(8);
	for (i = 4; i < 8; i++) wr(OFF_CLEAR, 32'((i + 1) * 16));
	rdchk(OFF_PEND, 32'h00000000);
	wr(OFF_MODE_HI, 32'h00000000);
	$display("test sense and priority done");

	i_iea_core_model.op(4'h2, 32'h00000000);
	wr(OFF_MODE_LO, 32'h00002100);
	src_in[1] <= 1'b1;
	cyc_wait(12);
	rdchk(OFF_PEND, 32'h00000002);
	check(32'(n_take), 32'd0);
	i_iea_core_model.op(4'h3, 32'h0);
	k = 0;
	while (core_take !== 1'b1 && k < 20) begin
		@(posedge mclk);
		k++;
	end
	check(32'(k), 32'd4);
	check({29'h0, stat_flags}, 32'h3);
	check({29'h0, core_level}, 32'h2);
	check({31'h0, redirect}, 32'h1);
	check(redirect_pc, INT_VEC_ADDR);
	check(return_pc_save, 32'h00001000);
	check({29'h0, bank_sel}, 32'h2);
	rdchk(OFF_MASK, 32'h00000002);
	rdchk(OFF_CORE, 32'h00000023);
	src_in[1] <= 1'b0;
	cyc_wait(8);
	wr(OFF_CLEAR, 32'h00000020);
	rdchk(OFF_VECTOR, 32'h00000000);
	check(32'(n_take), 32'd1);
	i_iea_core_model.op(4'h5, 32'h0);
	cyc_wait(3);
	check({29'h0, stat_flags}, 32'h1);
	check(redirect_pc, 32'h00001000);
	check({29'h0, bank_sel}, 32'h0);
	$display("test acceptance done");

	src_in[1] <= 1'b1;
	cyc_wait(12);
	check(32'(n_take), 32'd1);
	wr(OFF_MASK, 32'h80000000);
	cyc_wait(12);
	check(32'(n_take), 32'd2);
	handler();
	for (i = 0; i < 2; i++) begin
		i_iea_core_model.op(4'h6 + 4'(i), 32'h0);
		cyc_wait(3);
		check({29'h0, stat_flags}, (i == 0) ? 32'h3 : 32'h5);
		src_in[1] <= 1'b1;
		cyc_wait(12);
		check(32'(n_take), 32'(2 + i));
		i_iea_core_model.op(4'h5, 32'h0);
		cyc_wait(8);
		check(32'(n_take), 32'(3 + i));
		handler();
	end
	$display("test mask and flags done");

	wr(OFF_MODE_LO, 32'h00000000);
	// Start disabled so the first enable method really flips the bit
	i_iea_core_model.op(4'h4, 32'h0);
	@(posedge mclk);
	check({29'h0, stat_flags}, 32'h0);
	for (i = 0; i < 3; i++) begin
		i_iea_core_model.op(on_k[i], on_d[i]);
		@(posedge mclk);
		check({29'h0, stat_flags}, 32'h1);
		i_iea_core_model.op(off_k[i], 32'h0);
		@(posedge mclk);
		check({29'h0, stat_flags}, 32'h0);
	end
	$display("test enable methods done");

	wr(OFF_EDGE, 32'h00000003);
	rdchk(OFF_EDGE, 32'h00000000);
	wr(OFF_KEY, 32'h00000055);
	rdchk(OFF_KEY, 32'h00000001);
	wr(OFF_KEY, 32'h000000aa);
	rdchk(OFF_KEY, 32'h00000003);
	wr(OFF_EDGE, 32'h00000005);
	rdchk(OFF_EDGE, 32'h00000005);
	rdchk(OFF_KEY, 32'h00000000);
	wr(OFF_EDGE, 32'h0000000a);
	rdchk(OFF_EDGE, 32'h00000005);
	i_iea_core_model.op(4'h8, 32'h0);
	@(posedge mclk);
	check({31'h0, core_stall}, 32'h1);
	k = 0;
	while (core_stall === 1'b1 && k < 50) begin
		@(posedge mclk);
		k++;
	end
	check({31'h0, core_stall}, 32'h0);
	$display("test key and barrier done");
	end_of_test();
end
endmodule
